// *** verilog/ccs_pkg.sv ***
// shared constants and state type for the codec clock source block
// assumes an apb slave clocked by pclk at 100 mhz, asynchronous presetn
package ccs_pkg;

    // bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h10;
    localparam logic [7:0] OFS_SRC = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1c;

    // source select field positions (two bits each)
    localparam int SRC_DAC2_LSB = 10;
    localparam int SRC_DAC1_LSB = 8;
    localparam int SRC_ADCR_LSB = 2;
    localparam int SRC_ADCL_LSB = 0;

    // generator one mode field positions and the control off bit
    localparam int MODE_REF_BIT = 15;
    localparam int MODE_VID_BIT = 14;
    localparam int MODE_GAIN_BIT = 13;
    localparam int MODE_P200_BIT = 12;
    localparam int MODE_X87_BIT = 11;
    localparam int MODE_C128_BIT = 10;
    localparam int CTRL_OFF_BIT = 0;

    // writable bits and reset values
    localparam logic [15:0] SRC_MASK = 16'h0f0f;
    localparam logic [15:0] MODE_MASK = 16'hfcff;
    localparam logic [15:0] SRC_RST = 16'h0000;
    localparam logic [15:0] MODE_RST = 16'h00ff;
    localparam logic CTRL_RST = 1'h0;

    // rate widths
    localparam int RATE_W = 17;
    localparam int BIT_W = 24;

    // fixed frequencies in hz, then shift and code limits
    localparam logic [16:0] FIXED_HZ = 17'h0bb80;
    localparam logic [31:0] BIT_STEP_HZ = 32'h00000960;
    localparam logic [31:0] PLUS_HZ = 32'h000000c8;
    localparam int PIN_SHIFT = 7;
    localparam logic [3:0] BITCODE_MAX = 4'hb;
    localparam logic [3:0] DIV_MAX = 4'h7;
    localparam logic [7:0] MOD_TIMES_PIN = 8'hff;

    // per-channel source codes
    typedef enum logic [1:0] {
        SRC_FIXED = 2'b00,
        SRC_GEN1 = 2'b01,
        SRC_GEN2 = 2'b10,
        SRC_GEN3 = 2'b11
    } ccs_src_t;

    // whole state of the block
    typedef struct packed {
        logic [1:0] pd_sync;
        logic [15:0] src;
        logic [15:0] mode;
        logic conv_off;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [16:0] r_dac2;
        logic [16:0] r_dac1;
        logic [16:0] r_adcr;
        logic [16:0] r_adcl;
        logic [16:0] g1_conv;
        logic [23:0] g1_bit;
        logic [23:0] g1_pin;
        logic bit_en;
        logic ref_sync;
        logic loop_gain;
    } ccs_state_t;

endpackage

// *** verilog/ccs_clock_source.sv ***
// per-channel sample rate source select and generator one mode control
// assumes an apb master on pclk; rates of generators two and three and the
// generator one rate register value arrive from logic on the same clock
//
// Notes on behaviour
// - second dac takes 48 khz or generator one, two or three by code.
// - first dac uses its own selector with the same four-way encoding.
// - right adc selector: 00 fixed, 01 gen one, 10 gen two, 11 gen three.
// - left adc selector: 00 fixed, 01, 10, 11 generators one to three.
// - source select resets to zero, cleared by reset, power-down, off bit.
// - master clock reference uses rate register, 8/7, modifiers, plus 200.
// - sync reference ignores rate, phase and the 8/7 bit.
// - normal sync lock keeps bit clock; video lock produces none.
// - loop gain bit picks finite at zero, infinite at one.
// - plus 200 bit raises table-step bit clock by 200 hz, ignored in video and with both nibbles 1111.
// - 8/7 bit scales conversion rate, ignored under sync reference.
// - conversion pin runs at 128 times rate when its bit is set.
// - low modifier nibble picks bit clock in 2400 hz steps, to 1011.
// - bit clock scales by actual rate over the coded rate.
// - both nibbles 1111 give a bit clock of 128 times the rate.
// - video standard bit: zero ntsc, one pal; sync must match.
// - video lock conversion rate is base divided by divisor.
// - base codes map to fixed rates; divisor codes 0 to 7 mean 1 to 8.
// - mode register resets to 00ff, cleared by reset or power-down.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

module ccs_clock_source
    import ccs_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins and neighbouring generators
    input wire logic power_down_pin_n,
    input wire logic [15:0] gen_one_rate_value,
    input wire logic [16:0] gen_two_rate_hz,
    input wire logic [16:0] gen_three_rate_hz,
    // per-channel conversion rates in hz
    output logic [16:0] dac_two_rate_hz,
    output logic [16:0] dac_one_rate_hz,
    output logic [16:0] adc_right_rate_hz,
    output logic [16:0] adc_left_rate_hz,
    // generator one targets
    output logic [16:0] gen_one_conv_hz,
    output logic [23:0] gen_one_bitclk_hz,
    output logic [23:0] gen_one_conv_pin_hz,
    output logic gen_one_bitclk_en,
    output logic gen_one_reference_select,
    output logic gen_one_loop_gain
);

    ccs_state_t s_q;
    ccs_state_t s_d;

    // nominal rate named by the high modifier nibble, zero when reserved
    function automatic logic [31:0] coded_rate(input logic [3:0] nib);
        logic [31:0] r;
        r = 32'h0;
        case (nib)
            4'h0: r = 32'h00001c20;
            4'h1: r = 32'h000020d0;
            4'h2: r = 32'h00002328;
            4'h3: r = 32'h00002580;
            4'h4: r = 32'h00002bc0;
            4'h5: r = 32'h00002ee0;
            4'h6: r = 32'h00003200;
            4'h7: r = (32'h00001c20 * 32'h8) / 32'h7;
            4'h8: r = (32'h00002328 * 32'h8) / 32'h7;
            4'h9: r = (32'h00002580 * 32'h8) / 32'h7;
            4'ha: r = (32'h00002ee0 * 32'h8) / 32'h7;
            default: r = 32'h0;
        endcase
        return r;
    endfunction

    // video lock base rate; the last two codes exist for ntsc only
    function automatic logic [31:0] video_base(input logic [2:0] code,
                                               input logic pal);
        logic [31:0] r;
        r = 32'h0;
        case (code)
            3'h0: r = 32'h0000bb80;
            3'h1: r = 32'h00007d00;
            3'h2: r = 32'h0000ac44;
            3'h3: r = (32'h0000ac44 * 32'h2) / 32'h3;
            3'h4: r = pal ? 32'h0 : 32'h0000bb80;
            3'h5: r = pal ? 32'h0 : 32'h0000ac18;
            default: r = 32'h0;
        endcase
        return r;
    endfunction

    // four-way source pick shared by all channels
    function automatic logic [16:0] pick(input logic [1:0] code,
                                         input logic [16:0] g1,
                                         input logic [16:0] g2,
                                         input logic [16:0] g3);
        logic [16:0] r;
        r = FIXED_HZ;
        case (ccs_src_t'(code))
            SRC_FIXED: r = FIXED_HZ;
            SRC_GEN1: r = g1;
            SRC_GEN2: r = g2;
            SRC_GEN3: r = g3;
            default: r = FIXED_HZ;
        endcase
        return r;
    endfunction

    // decoded views of the current state
    logic pd_n;
    logic src_hold;
    logic video;
    logic [7:0] mods;
    assign pd_n = s_q.pd_sync[1];
    assign src_hold = !pd_n || s_q.conv_off;
    assign video = s_q.mode[MODE_REF_BIT] && s_q.mode[MODE_VID_BIT];
    assign mods = s_q.mode[7:0];

    // next state: bus, register clears and rate arithmetic
    always_comb begin
        logic [31:0] conv;
        logic [31:0] nom;
        logic [31:0] coded;
        logic [31:0] bitc;
        logic [31:0] pin;
        logic [15:0] wd;
        logic setup;
        logic wr;
        logic hit;
        conv = 32'h0;
        nom = 32'h0;
        coded = coded_rate(mods[7:4]);
        bitc = 32'h0;
        pin = 32'h0;
        wd = pwdata[15:0];
        setup = psel && !penable;
        wr = psel && penable && pwrite && s_q.pready;
        hit = (paddr == OFS_MODE) || (paddr == OFS_SRC) ||
              (paddr == OFS_CTRL) || (paddr == OFS_STAT);
        s_d = s_q;

        // power-down pin passes two flops before use
        s_d.pd_sync = {s_q.pd_sync[0], power_down_pin_n};

        // one cycle access: ready rises in the access phase
        s_d.pready = setup;
        s_d.pslverr = setup && !hit;
        s_d.prdata = 32'h0;
        if (setup) begin
            case (paddr)
                OFS_MODE: s_d.prdata = {16'h0, s_q.mode};
                OFS_SRC: s_d.prdata = {16'h0, s_q.src};
                OFS_CTRL: s_d.prdata = {31'h0, s_q.conv_off};
                OFS_STAT: s_d.prdata = {28'h0, pd_n, video,
                                        s_q.bit_en, s_q.ref_sync};
                default: s_d.prdata = 32'h0;
            endcase
        end

        // writes, reserved bits dropped
        if (wr && paddr == OFS_MODE) begin
            s_d.mode = wd & MODE_MASK;
        end
        if (wr && paddr == OFS_SRC) begin
            s_d.src = wd & SRC_MASK;
        end
        if (wr && paddr == OFS_CTRL) begin
            s_d.conv_off = pwdata[CTRL_OFF_BIT];
        end

        // clears hold off writes for as long as they last
        if (src_hold) begin
            s_d.src = SRC_RST;
        end
        if (!pd_n) begin
            s_d.mode = MODE_RST;
        end

        // generator one conversion rate by reference
        if (video) begin
            if (mods[3:0] <= DIV_MAX) begin
                conv = video_base(mods[6:4], mods[7]) /
                       ({28'h0, mods[3:0]} + 32'h1);
            end
        end else if (s_q.mode[MODE_REF_BIT]) begin
            conv = coded;
        end else if (s_q.mode[MODE_X87_BIT]) begin
            conv = ({16'h0, gen_one_rate_value} * 32'h8) / 32'h7;
        end else begin
            conv = {16'h0, gen_one_rate_value};
        end

        // bit clock: none in video lock, else 128x, table step, or none past low code 1011
        if (video) begin
            bitc = 32'h0;
        end else if (mods == MOD_TIMES_PIN) begin
            bitc = conv << PIN_SHIFT;
        end else if (mods[3:0] <= BITCODE_MAX) begin
            nom = ({28'h0, mods[3:0]} + 32'h1) * BIT_STEP_HZ;
            bitc = (coded != 32'h0) ? (nom * conv) / coded : nom;
            if (s_q.mode[MODE_P200_BIT]) begin
                bitc = bitc + PLUS_HZ;
            end
        end

        // conversion pin, internal rate untouched
        pin = s_q.mode[MODE_C128_BIT] ? (conv << PIN_SHIFT) : conv;

        s_d.g1_conv = conv[RATE_W-1:0];
        s_d.g1_bit = bitc[BIT_W-1:0];
        s_d.g1_pin = pin[BIT_W-1:0];
        s_d.bit_en = !video;
        s_d.ref_sync = s_q.mode[MODE_REF_BIT];
        s_d.loop_gain = s_q.mode[MODE_GAIN_BIT];

        // channel routing, using last registered generator one rate
        s_d.r_dac2 = pick(s_q.src[SRC_DAC2_LSB +: 2], s_q.g1_conv,
                          gen_two_rate_hz, gen_three_rate_hz);
        s_d.r_dac1 = pick(s_q.src[SRC_DAC1_LSB +: 2], s_q.g1_conv,
                          gen_two_rate_hz, gen_three_rate_hz);
        s_d.r_adcr = pick(s_q.src[SRC_ADCR_LSB +: 2], s_q.g1_conv,
                          gen_two_rate_hz, gen_three_rate_hz);
        s_d.r_adcl = pick(s_q.src[SRC_ADCL_LSB +: 2], s_q.g1_conv,
                          gen_two_rate_hz, gen_three_rate_hz);
    end

    // single state register; reset loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.src <= SRC_RST;
            s_q.mode <= MODE_RST;
            s_q.conv_off <= CTRL_RST;
            s_q.r_dac2 <= FIXED_HZ;
            s_q.r_dac1 <= FIXED_HZ;
            s_q.r_adcr <= FIXED_HZ;
            s_q.r_adcl <= FIXED_HZ;
            s_q.bit_en <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign dac_two_rate_hz = s_q.r_dac2;
    assign dac_one_rate_hz = s_q.r_dac1;
    assign adc_right_rate_hz = s_q.r_adcr;
    assign adc_left_rate_hz = s_q.r_adcl;
    assign gen_one_conv_hz = s_q.g1_conv;
    assign gen_one_bitclk_hz = s_q.g1_bit;
    assign gen_one_conv_pin_hz = s_q.g1_pin;
    assign gen_one_bitclk_en = s_q.bit_en;
    assign gen_one_reference_select = s_q.ref_sync;
    assign gen_one_loop_gain = s_q.loop_gain;

    // checks on what the block drives
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_src_cleared: assert property (
        src_hold |=> s_q.src == SRC_RST)
        else $error("source select not cleared");

    a_mode_cleared: assert property (
        !pd_n |=> s_q.mode == MODE_RST)
        else $error("mode register not cleared");

    a_dac2_fixed: assert property (
        s_q.src[SRC_DAC2_LSB +: 2] == 2'b00 |=>
        dac_two_rate_hz == FIXED_HZ)
        else $error("dac two not on fixed rate");

    a_dac2_gen3: assert property (
        s_q.src[SRC_DAC2_LSB +: 2] == 2'b11 |=>
        dac_two_rate_hz == $past(gen_three_rate_hz))
        else $error("dac two not on generator three");

    a_dac1_gen1: assert property (
        s_q.src[SRC_DAC1_LSB +: 2] == 2'b01 |=>
        dac_one_rate_hz == $past(s_q.g1_conv))
        else $error("dac one not on generator one");

    a_adcr_gen1: assert property (
        s_q.src[SRC_ADCR_LSB +: 2] == 2'b01 |=>
        adc_right_rate_hz == $past(s_q.g1_conv))
        else $error("right adc not on generator one");

    a_adcr_gen2: assert property (
        s_q.src[SRC_ADCR_LSB +: 2] == 2'b10 |=>
        adc_right_rate_hz == $past(gen_two_rate_hz))
        else $error("right adc not on generator two");

    a_adcl_gen3: assert property (
        s_q.src[SRC_ADCL_LSB +: 2] == 2'b11 |=>
        adc_left_rate_hz == $past(gen_three_rate_hz))
        else $error("left adc not on generator three");

    // master reference with the 8/7 bit clear passes the rate register value straight through
    a_master_rate: assert property (
        !s_q.mode[MODE_REF_BIT] && !s_q.mode[MODE_X87_BIT] |=>
        32'(gen_one_conv_hz) == 32'($past(gen_one_rate_value)))
        else $error("master reference rate wrong");

    // normal sync lock reports the nominal rate of code 0011
    a_sync_nominal: assert property (
        s_q.mode[MODE_REF_BIT] && !video && mods[7:4] == 4'h3 |=>
        gen_one_conv_hz == 17'h02580)
        else $error("sync lock rate not nominal");

    a_video_nobit: assert property (
        video |=> !gen_one_bitclk_en && gen_one_bitclk_hz == 24'h0)
        else $error("bit clock present in video lock");

    a_gain_copy: assert property (
        s_q.mode[MODE_GAIN_BIT] |=> gen_one_loop_gain)
        else $error("loop gain not infinite");

    // 9600 hz table step at nominal rate, plus the 200 hz offset
    a_plus_offset: assert property (
        !video && s_q.mode[MODE_P200_BIT] && mods == 8'h33 &&
        s_q.mode[MODE_REF_BIT] |=> gen_one_bitclk_hz == 24'h002648)
        else $error("bit clock offset missing");

    a_x87_scale: assert property (
        !s_q.mode[MODE_REF_BIT] && s_q.mode[MODE_X87_BIT] |=>
        32'(gen_one_conv_hz) ==
        (32'($past(gen_one_rate_value)) * 32'h8) / 32'h7)
        else $error("8/7 scaling wrong");

    a_pin_times: assert property (
        s_q.mode[MODE_C128_BIT] ##1 s_q.mode[MODE_C128_BIT] |=>
        gen_one_conv_pin_hz == {gen_one_conv_hz, 7'h0})
        else $error("conversion pin not 128 times rate");

    a_pin_plain: assert property (
        !s_q.mode[MODE_C128_BIT] |=>
        gen_one_conv_pin_hz == {7'h0, gen_one_conv_hz})
        else $error("conversion pin not at rate");

    a_mux_times: assert property (
        !video && mods == MOD_TIMES_PIN |=>
        32'(gen_one_bitclk_hz) == 32'(s_q.g1_conv) << PIN_SHIFT)
        else $error("bit clock not 128 times rate");

    // ntsc base 32000 hz over divisor two
    a_video_div: assert property (
        video && mods == 8'h11 |=> gen_one_conv_hz == 17'h03e80)
        else $error("video divisor not applied");

    a_apb_ready: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("apb ready not a single cycle");

    c_video_lock: cover property (video ##1 gen_one_conv_hz != 17'h0);
    c_sync_lock: cover property (s_q.mode[MODE_REF_BIT] && !video ##1
                                 gen_one_bitclk_en);
    c_src_write: cover property (psel && penable && pwrite && pready &&
                                 paddr == OFS_SRC && !src_hold);
    c_pd_clear: cover property (pd_n ##1 !pd_n);
    c_bad_addr: cover property (pslverr);

endmodule

// *** verification/test_sample_rate_source_and_clockgen_mode.sv ***
// self-checking bench for the clock source select and generator one mode
// assumes ccs_pkg and ccs_clock_source compiled first; apb driven by bench
`timescale 1ns/1ps
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin num_errors++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (g), (x)); end end

module test_sample_rate_source_and_clockgen_mode
    import ccs_pkg::*;
;
    // apb and pins
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pd_n = 1'b1;
    logic [15:0] rv = 16'h1f40;
    logic [16:0] g2 = 17'h07d00;
    logic [16:0] g3 = 17'h0ac44;
    // observed rates
    logic [16:0] r_d2, r_d1, r_ar, r_al, conv;
    logic [23:0] bclk, pin;
    logic ben, refs, gain;
    logic [31:0] r;
    logic e;
    int num_errors = 0;
    int checks = 0;
    logic [16:0] vbase [6] = '{17'h0bb80, 17'h07d00, 17'h0ac44, 17'h072d8,
        17'h0bb80, 17'h0ac18};

    ccs_clock_source DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_down_pin_n(pd_n), .gen_one_rate_value(rv),
        .gen_two_rate_hz(g2), .gen_three_rate_hz(g3),
        .dac_two_rate_hz(r_d2), .dac_one_rate_hz(r_d1),
        .adc_right_rate_hz(r_ar), .adc_left_rate_hz(r_al),
        .gen_one_conv_hz(conv), .gen_one_bitclk_hz(bclk),
        .gen_one_conv_pin_hz(pin), .gen_one_bitclk_en(ben),
        .gen_one_reference_select(refs), .gen_one_loop_gain(gain));

    always #5 pclk = ~pclk;

    // one apb transfer; waits an edge first so no signal is set twice
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // derived outputs lag a write by two edges, three gives margin
    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask

    task automatic md(input logic [15:0] m, input logic [15:0] v);
        @(posedge pclk);
        rv <= v;
        apb(1'b1, OFS_MODE, {16'h0, m});
        settle();
    endtask

    task automatic t_reset();
        apb(1'b0, OFS_MODE, 32'h0);
        `CHK(r, 32'h000000ff)
        apb(1'b0, OFS_SRC, 32'h0);
        `CHK(r, 32'h00000000)
        `CHK(r_d2, FIXED_HZ)
        apb(1'b0, 8'h20, 32'h0);
        `CHK({e, r}, {1'b1, 32'h0})
    endtask

    task automatic t_src();
        logic [16:0] x [4];
        x = '{FIXED_HZ, {1'b0, rv}, g2, g3};
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, OFS_SRC, 32'(c * 16'h0505));
            settle();
            `CHK(r_d2, x[c])
            `CHK(r_d1, x[c])
            `CHK(r_ar, x[c])
            `CHK(r_al, x[c])
        end
        apb(1'b1, OFS_SRC, 32'h00000e09);
        settle();
        `CHK({r_d2, r_d1, r_al}, {g3, g2, 1'b0, rv})
        `CHK(r_ar, g2)
    endtask

    // off bit and power-down both clear the selector and block writes
    task automatic t_clear();
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK(r, 32'h1)
        apb(1'b1, OFS_SRC, 32'h00000505);
        apb(1'b0, OFS_SRC, 32'h0);
        `CHK(r, 32'h0)
        settle();
        `CHK(r_al, FIXED_HZ)
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_SRC, 32'h00000505);
        apb(1'b1, OFS_MODE, 32'h00001c33);
        @(posedge pclk);
        pd_n <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, OFS_SRC, 32'h00000a0a);
        apb(1'b1, OFS_MODE, 32'h00001234);
        apb(1'b0, OFS_SRC, 32'h0);
        `CHK(r, 32'h0)
        apb(1'b0, OFS_MODE, 32'h0);
        `CHK(r, 32'h000000ff)
        @(posedge pclk);
        pd_n <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask

    // reset pin in mid-run returns both registers to their defaults
    task automatic t_rst();
        apb(1'b1, OFS_SRC, 32'h00000505);
        apb(1'b1, OFS_MODE, 32'h00001c33);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, OFS_SRC, 32'h0);
        `CHK(r, 32'h0)
        `CHK(r_d1, FIXED_HZ)
        apb(1'b0, OFS_MODE, 32'h0);
        `CHK(r, 32'h000000ff)
    endtask

    task automatic t_master();
        md(16'h1c00, 16'h1c20);
        `CHK(conv, 17'h02024)
        `CHK(pin, 24'h101200)
        `CHK(bclk, 24'h000b7e)
        `CHK({refs, ben}, 2'b01)
        md(16'h0000, 16'h1c20);
        `CHK(conv, 17'h01c20)
        `CHK(pin, 24'h001c20)
        `CHK(bclk, 24'h000960)
        md(16'h0871, 16'h1c20);
        `CHK(conv, 17'h02024)
        `CHK(bclk, 24'h0012c0)
        `CHK(pin, 24'h002024)
    endtask

    task automatic t_steps();
        logic [23:0] x;
        for (int lo = 0; lo < 16; lo++) begin
            md({12'h003, 4'(lo)}, 16'h2580);
            x = (lo <= BITCODE_MAX) ? 24'((lo + 1) * BIT_STEP_HZ) : 24'h0;
            `CHK(bclk, x)
        end
        md(16'h003b, 16'h12c0);
        `CHK(bclk, 24'h003840)
        md(16'h00ff, 16'h2580);
        `CHK(bclk, 24'h12c000)
    endtask

    task automatic t_sync();
        apb(1'b1, OFS_SRC, 32'h00000100);
        md(16'ha833, 16'h1c20);
        `CHK(conv, 17'h02580)
        `CHK(r_d1, 17'h02580)
        `CHK({refs, gain, ben}, 3'b111)
        `CHK(bclk, 24'h002580)
        apb(1'b0, OFS_STAT, 32'h0);
        `CHK(r, 32'h0000000b)
        md(16'h9833, 16'h1c20);
        `CHK(gain, 1'b0)
        `CHK(bclk, 24'h002648)
    endtask

    // plus-200 set throughout video lock; it must not revive the bit clock
    task automatic t_video();
        for (int b = 0; b < 6; b++) begin
            md(16'hd000 | 16'(b * 16'h0011), 16'h1c20);
            `CHK(conv, 17'(vbase[b] / 17'(b + 1)))
            `CHK({ben, bclk}, 25'h0)
        end
        apb(1'b0, OFS_STAT, 32'h0);
        `CHK(r, 32'h0000000d)
        md(16'hd0a7, 16'h1c20);
        `CHK(conv, 17'h01588)
        md(16'hd0c0, 16'h1c20);
        `CHK(conv, 17'h0)
        md(16'hd028, 16'h1c20);
        `CHK(conv, 17'h0)
    endtask

    task automatic print_verdict();
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_reset();
        t_src();
        t_clear();
        t_rst();
        t_master();
        t_steps();
        t_sync();
        t_video();
        print_verdict();
    end

    // watchdog, run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        print_verdict();
    end
endmodule
